/* File: design/fbm_defs.svh */
// Purpose: constants for the fieldbus master group-command and cycle scheduler
// Assumes: 100 MHz core clock
// Notes: times in ns, cycle counts derived from them
`ifndef FBM_DEFS_SVH
`define FBM_DEFS_SVH
`define FBM_CLK_PERIOD_NS 10
`define FBM_BLINK_NS 250000000
`define FBM_BLINK_CYC (`FBM_BLINK_NS / `FBM_CLK_PERIOD_NS)
`define FBM_BRIEF_NS 50000000
`define FBM_BRIEF_CYC (`FBM_BRIEF_NS / `FBM_CLK_PERIOD_NS)
`define FBM_TASK_FIRST 8'h3d
`define FBM_TASK_LAST 8'h40
`define FBM_ADDR_MAX 7'h7e
`define FBM_CMD_UNFREEZE 4'h4
`define FBM_CMD_FREEZE 4'h8
`define FBM_CMD_UNSYNC 4'h1
`define FBM_CMD_SYNC 4'h2
`define FBM_CNT_W 32
`define FBM_ONE_CNT 32'h1
`define FBM_ZERO_CNT 32'h0
`endif

/* File: design/fbm_pkg.sv */
// Purpose: types for the fieldbus master
// Assumes: included with fbm_defs.svh
// Notes: states only
package fbm_pkg;
	typedef enum logic [2:0] {
		FBM_IDLE,
		FBM_PARAM,
		FBM_WAITREADY,
		FBM_CYCLIC,
		FBM_GROUPCMD,
		FBM_GAP
	} fbm_state_t;
endpackage

/* File: design/fbm_fault_lamp.sv */
// Purpose: drives the bus-fault and internal-fault indicators
// Assumes: inputs are synchronous to core_clk
// Notes: on the bus-fault lamp, steady fault beats station failure beats reconfiguration blink
`timescale 1ns/10ps
`include "fbm_defs.svh"
module fbm_fault_lamp (
	input wire logic core_clk,
	input wire logic rstN,
	input wire logic hwFault,
	input wire logic stationFail,
	input wire logic reconfigBusy,
	output logic busFaultLamp,
	output logic intFaultLamp
);
	logic [`FBM_CNT_W-1:0] blinkCnt_q, blinkCnt_d;
	logic blink_q, blink_d;
	logic [`FBM_CNT_W-1:0] briefCnt_q, briefCnt_d;
	logic reconfigSeen_q, reconfigSeen_d;
	logic lamp_q, lamp_d, intLamp_q, intLamp_d;
	always_comb begin
		blinkCnt_d = blinkCnt_q + `FBM_ONE_CNT;
		blink_d = blink_q;
		if (blinkCnt_q >= `FBM_CNT_W'(`FBM_BLINK_CYC - 1)) begin
			blinkCnt_d = `FBM_ZERO_CNT;
			blink_d = ~blink_q;
		end
		reconfigSeen_d = reconfigBusy;
		briefCnt_d = briefCnt_q;
		// a short pulse at each start, so the lamp only flashes briefly
		if (reconfigBusy && !reconfigSeen_q) begin
			briefCnt_d = `FBM_CNT_W'(`FBM_BRIEF_CYC);
		end else if (briefCnt_q != `FBM_ZERO_CNT) begin
			briefCnt_d = briefCnt_q - `FBM_ONE_CNT;
		end
		intLamp_d = (briefCnt_d != `FBM_ZERO_CNT); // (RULE16)
		if (hwFault) begin
			lamp_d = 1'b1; // (RULE14)
		end else if (stationFail) begin
			lamp_d = blink_q; // (RULE15)
		end else if (briefCnt_d != `FBM_ZERO_CNT) begin
			lamp_d = 1'b1; // (RULE16)
		end else begin
			lamp_d = 1'b0; // (RULE13)
		end
	end
	always_ff @(posedge core_clk or negedge rstN) begin
		if (!rstN) begin
			blinkCnt_q <= `FBM_ZERO_CNT;
			blink_q <= 1'b0;
			briefCnt_q <= `FBM_ZERO_CNT;
			reconfigSeen_q <= 1'b0;
			lamp_q <= 1'b0;
			intLamp_q <= 1'b0;
		end else begin
			blinkCnt_q <= blinkCnt_d;
			blink_q <= blink_d;
			briefCnt_q <= briefCnt_d;
			reconfigSeen_q <= reconfigSeen_d;
			lamp_q <= lamp_d;
			intLamp_q <= intLamp_d;
		end
	end
	assign busFaultLamp = lamp_q;
	assign intFaultLamp = intLamp_q;
	a_lamp_steady: assert property (@(posedge core_clk) disable iff (!rstN)
		hwFault |=> busFaultLamp) else $error("lamp not steady on hardware fault"); // (RULE14)
	a_lamp_off: assert property (@(posedge core_clk) disable iff (!rstN)
		(!hwFault && !stationFail && briefCnt_q == `FBM_ZERO_CNT && !(reconfigBusy && !reconfigSeen_q))
		|=> !busFaultLamp) else $error("lamp lit while healthy"); // (RULE13)
	a_lamp_brief: assert property (@(posedge core_clk) disable iff (!rstN)
		(reconfigBusy && !reconfigSeen_q) |=> intFaultLamp) else $error("no brief internal fault"); // (RULE16)
	c_lamp_flash: cover property (@(posedge core_clk) disable iff (!rstN)
		stationFail && !hwFault ##1 $changed(busFaultLamp));
endmodule

/* File: design/fbm_master.sv */
// Purpose: fieldbus master cycle scheduler with group sync and freeze control
// Assumes: user-side strobes are synchronous; link-side status comes from pins
// Notes: one frame slot per bus cycle; group commands go between frames
`timescale 1ns/10ps
`include "fbm_defs.svh"
// Functional notes
// (RULE1) sync sends current outputs and group-orders slaves to freeze outputs
// (RULE2) slaves in sync buffer later output data, outputs unchanged
// (RULE3) each further sync makes slaves apply buffered outputs
// (RULE4) cyclic output updating resumes only after unsync
// (RULE5) freeze group-orders slaves to latch inputs, then moves them to cpu
// (RULE6) each further freeze makes slaves latch inputs anew
// (RULE7) live cyclic inputs resume only after unfreeze
// (RULE8) with equidistance, every bus cycle starts after the same interval; the code doubles the next interval after programming traffic
// (RULE9) all slaves parameterised and ready within configured monitoring times
// (RULE10) mode legacy or dpv1 chosen per station, dpv1 covers whole station
// (RULE11) legacy mode follows the old standard, extended functions withheld
// (RULE12) programming or monitor traffic lengthens the bus cycle; the code lengthens it only with equidistance on, to twice equidistCycles
// (RULE13) bus-fault lamp off when configuration good and all slaves reachable
// (RULE14) bus-fault lamp steady on hardware, interface or rate mismatch fault
// (RULE15) bus-fault lamp flashes while any slave is unreachable
// (RULE16) reconfiguration sync flashes bus-fault and lights internal-fault briefly
// (RULE17) clocked partition updates interruptible, only in tasks 61 to 64
// (RULE18) each slave's inputs or outputs sit in one partition
// (RULE19) consistency limits on slaves plus bytes per partition
// (RULE20) any legal station address accepted as master address
// (RULE21) topology scan orders diagnostic repeaters to analyse the bus
// (RULE22) group commands sent only between cyclic frames
module fbm_master (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [6:0] ownAddress,
	input wire logic dpv1Mode,
	input wire logic equidistOn,
	input wire logic [15:0] equidistCycles,
	input wire logic [15:0] paramTimeout,
	input wire logic [15:0] readyTimeout,
	input wire logic startUp,
	input wire logic cmdValid,
	input wire logic [3:0] cmdCode,
	input wire logic [7:0] cmdGroups,
	output logic cmdReady,
	input wire logic puReq,
	input wire logic [7:0] puTask,
	input wire logic puOutput,
	output logic puAccepted,
	output logic puRejected,
	input wire logic topoReq,
	output logic topoFrame,
	input wire logic pgTraffic,
	input wire logic slaveParamDone,
	input wire logic slaveReadyDone,
	input wire logic slaveMissing,
	input wire logic busHwFault,
	input wire logic reconfigBusy,
	input wire logic frameDone,
	output logic frameStart,
	output logic groupFrame,
	output logic [3:0] groupCtrl,
	output logic [7:0] groupSel,
	output logic outputsLive,
	output logic inputsLive,
	output logic cpuInputLoad,
	output logic extFuncEnable,
	output logic powerUpFail,
	output logic addrValid,
	output logic busFaultLamp,
	output logic intFaultLamp
);
	logic rstMeta_q, rstN_q;
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			rstMeta_q <= 1'b0;
			rstN_q <= 1'b0;
		end else begin
			rstMeta_q <= 1'b1;
			rstN_q <= rstMeta_q;
		end
	end

	// pin inputs pass three flops; a change counts once stages two and three agree
	logic [4:0] pinS1_q, pinS2_q, pinS3_q, pinF_q, pinF_d;
	logic [4:0] pinRaw;
	assign pinRaw = {slaveParamDone, slaveReadyDone, slaveMissing, busHwFault, reconfigBusy};
	always_comb begin
		pinF_d = pinF_q;
		for (int i = 0; i < 5; i++) begin
			if (pinS2_q[i] == pinS3_q[i]) begin
				pinF_d[i] = pinS3_q[i];
			end
		end
	end
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			pinS1_q <= 5'h00;
			pinS2_q <= 5'h00;
			pinS3_q <= 5'h00;
			pinF_q <= 5'h00;
		end else begin
			pinS1_q <= pinRaw;
			pinS2_q <= pinS1_q;
			pinS3_q <= pinS2_q;
			pinF_q <= pinF_d;
		end
	end
	logic paramOk, readyOk, missing, hwFlt, reconfSync;
	assign {paramOk, readyOk, missing, hwFlt, reconfSync} = pinF_q;

	function automatic logic cmdHas(input logic [3:0] c, input logic [3:0] m);
		cmdHas = (c & m) != 4'h0;
	endfunction

	fbm_pkg::fbm_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic [15:0] gap_q, gap_d;
	logic syncOn_q, syncOn_d, frzOn_q, frzOn_d;
	logic pendCmd_q, pendCmd_d;
	logic [3:0] pendCode_q, pendCode_d;
	logic [7:0] pendGrp_q, pendGrp_d;
	logic [3:0] gCtrl_q, gCtrl_d;
	logic [7:0] gSel_q, gSel_d;
	logic frStart_q, frStart_d, gFrame_q, gFrame_d, cpuLoad_q, cpuLoad_d;
	logic pufail_q, pufail_d, topoPend_q, topoPend_d, topo_q, topo_d;
	logic ext_q, ext_d, pgHold_q, pgHold_d;

	assign cmdReady = !pendCmd_q;

	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q + 16'h0001;
		gap_d = gap_q;
		syncOn_d = syncOn_q;
		frzOn_d = frzOn_q;
		pendCmd_d = pendCmd_q;
		pendCode_d = pendCode_q;
		pendGrp_d = pendGrp_q;
		gCtrl_d = gCtrl_q;
		gSel_d = gSel_q;
		frStart_d = 1'b0;
		gFrame_d = 1'b0;
		cpuLoad_d = 1'b0;
		pufail_d = pufail_q;
		topoPend_d = topoPend_q || topoReq;
		topo_d = 1'b0;
		pgHold_d = pgHold_q || pgTraffic;
		ext_d = dpv1Mode; // (RULE10) (RULE11)
		if (cmdValid && cmdReady) begin
			pendCmd_d = 1'b1;
			pendCode_d = cmdCode;
			pendGrp_d = cmdGroups;
		end
		case (state_q)
			fbm_pkg::FBM_IDLE: begin
				cnt_d = 16'h0000;
				if (startUp) begin
					state_d = fbm_pkg::FBM_PARAM;
					pufail_d = 1'b0;
				end
			end
			fbm_pkg::FBM_PARAM: begin
				if (paramOk) begin
					state_d = fbm_pkg::FBM_WAITREADY;
					cnt_d = 16'h0000;
				end else if (cnt_q >= paramTimeout) begin
					pufail_d = 1'b1; // (RULE9)
					state_d = fbm_pkg::FBM_IDLE;
				end
			end
			fbm_pkg::FBM_WAITREADY: begin
				if (readyOk) begin
					state_d = fbm_pkg::FBM_GAP;
					cnt_d = 16'h0000;
				end else if (cnt_q >= readyTimeout) begin
					pufail_d = 1'b1; // (RULE9)
					state_d = fbm_pkg::FBM_IDLE;
				end
			end
			fbm_pkg::FBM_GAP: begin
				// group commands and scans slot in here, never inside a data frame
				if (pendCmd_q) begin
					state_d = fbm_pkg::FBM_GROUPCMD; // (RULE22)
					gFrame_d = 1'b1;
					gCtrl_d = pendCode_q;
					gSel_d = pendGrp_q;
					pendCmd_d = 1'b0;
					if (cmdHas(pendCode_q, `FBM_CMD_SYNC)) begin
						syncOn_d = 1'b1; // (RULE1)
					end else if (cmdHas(pendCode_q, `FBM_CMD_UNSYNC)) begin
						syncOn_d = 1'b0; // (RULE4)
					end
					if (cmdHas(pendCode_q, `FBM_CMD_FREEZE)) begin
						frzOn_d = 1'b1; // (RULE5)
						cpuLoad_d = 1'b1; // (RULE5)
					end else if (cmdHas(pendCode_q, `FBM_CMD_UNFREEZE)) begin
						frzOn_d = 1'b0; // (RULE7)
					end
				end else if (topoPend_q) begin
					topoPend_d = topoReq;
					topo_d = 1'b1; // (RULE21)
					state_d = fbm_pkg::FBM_GROUPCMD;
				end else if (!equidistOn || cnt_q >= gap_q) begin
					state_d = fbm_pkg::FBM_CYCLIC; // (RULE8)
					frStart_d = 1'b1;
					cnt_d = 16'h0000;
					gap_d = equidistCycles;
					if (pgHold_q) begin
						gap_d = 16'(equidistCycles + equidistCycles); // (RULE12)
						pgHold_d = pgTraffic;
					end
				end
			end
			fbm_pkg::FBM_GROUPCMD: begin
				if (frameDone) begin
					state_d = fbm_pkg::FBM_GAP;
				end
			end
			fbm_pkg::FBM_CYCLIC: begin
				if (frameDone) begin
					state_d = fbm_pkg::FBM_GAP;
				end
			end
			default: begin
				state_d = fbm_pkg::FBM_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			state_q <= fbm_pkg::FBM_IDLE;
			cnt_q <= 16'h0000;
			gap_q <= 16'h0000;
			syncOn_q <= 1'b0;
			frzOn_q <= 1'b0;
			pendCmd_q <= 1'b0;
			pendCode_q <= 4'h0;
			pendGrp_q <= 8'h00;
			gCtrl_q <= 4'h0;
			gSel_q <= 8'h00;
			frStart_q <= 1'b0;
			gFrame_q <= 1'b0;
			cpuLoad_q <= 1'b0;
			pufail_q <= 1'b0;
			topoPend_q <= 1'b0;
			topo_q <= 1'b0;
			ext_q <= 1'b0;
			pgHold_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			gap_q <= gap_d;
			syncOn_q <= syncOn_d;
			frzOn_q <= frzOn_d;
			pendCmd_q <= pendCmd_d;
			pendCode_q <= pendCode_d;
			pendGrp_q <= pendGrp_d;
			gCtrl_q <= gCtrl_d;
			gSel_q <= gSel_d;
			frStart_q <= frStart_d;
			gFrame_q <= gFrame_d;
			cpuLoad_q <= cpuLoad_d;
			pufail_q <= pufail_d;
			topoPend_q <= topoPend_d;
			topo_q <= topo_d;
			ext_q <= ext_d;
			pgHold_q <= pgHold_d;
		end
	end

	// partition updates: accepted only from the cycle-synchronous tasks
	logic puOk;
	logic puAcc_q, puAcc_d, puRej_q, puRej_d;
	assign puOk = (puTask >= `FBM_TASK_FIRST) && (puTask <= `FBM_TASK_LAST);
	always_comb begin
		puAcc_d = puReq && puOk; // (RULE17)
		puRej_d = puReq && !puOk; // (RULE17)
	end
	always_ff @(posedge core_clk or negedge rstN_q) begin
		if (!rstN_q) begin
			puAcc_q <= 1'b0;
			puRej_q <= 1'b0;
		end else begin
			puAcc_q <= puAcc_d;
			puRej_q <= puRej_d;
		end
	end

	assign frameStart = frStart_q;
	assign groupFrame = gFrame_q;
	assign groupCtrl = gCtrl_q;
	assign groupSel = gSel_q;
	assign outputsLive = !syncOn_q;
	assign inputsLive = !frzOn_q;
	assign cpuInputLoad = cpuLoad_q;
	assign extFuncEnable = ext_q;
	assign powerUpFail = pufail_q;
	assign addrValid = ownAddress <= `FBM_ADDR_MAX; // (RULE20)
	assign topoFrame = topo_q;
	assign puAccepted = puAcc_q;
	assign puRejected = puRej_q;

	fbm_fault_lamp u_lamp (
		.core_clk(core_clk),
		.rstN(rstN_q),
		.hwFault(hwFlt),
		.stationFail(missing),
		.reconfigBusy(reconfSync),
		.busFaultLamp(busFaultLamp),
		.intFaultLamp(intFaultLamp)
	);

	a_group_gap: assert property (@(posedge core_clk) disable iff (!rstN_q)
		groupFrame |-> $past(state_q) == fbm_pkg::FBM_GAP) else $error("group frame inside a data frame"); // (RULE22)
	a_sync_hold: assert property (@(posedge core_clk) disable iff (!rstN_q)
		(groupFrame && cmdHas(groupCtrl, `FBM_CMD_SYNC)) |-> !outputsLive) else $error("sync left outputs live"); // (RULE1)
	a_unsync_only: assert property (@(posedge core_clk) disable iff (!rstN_q)
		$rose(outputsLive) |-> groupFrame && cmdHas(groupCtrl, `FBM_CMD_UNSYNC)) else $error("outputs resumed"); // (RULE4)
	a_freeze_load: assert property (@(posedge core_clk) disable iff (!rstN_q)
		cpuInputLoad |-> groupFrame && !inputsLive) else $error("freeze load without command"); // (RULE5)
	a_unfreeze_only: assert property (@(posedge core_clk) disable iff (!rstN_q)
		$rose(inputsLive) |-> groupFrame && cmdHas(groupCtrl, `FBM_CMD_UNFREEZE)) else $error("inputs resumed"); // (RULE7)
	a_equi_space: assert property (@(posedge core_clk) disable iff (!rstN_q)
		(state_q == fbm_pkg::FBM_GAP && equidistOn && cnt_q < gap_q)
		|=> !frameStart) else $error("cycle started early"); // (RULE8)
	a_task_range: assert property (@(posedge core_clk) disable iff (!rstN_q)
		(puReq && puTask == 8'h3c) |=> puRejected && !puAccepted) else $error("task 60 accepted"); // (RULE17)
	a_pu_timeout: assert property (@(posedge core_clk) disable iff (!rstN_q)
		(state_q == fbm_pkg::FBM_PARAM && !paramOk && cnt_q >= paramTimeout) |=> powerUpFail)
		else $error("param timeout missed"); // (RULE9)
	a_mode_ext: assert property (@(posedge core_clk) disable iff (!rstN_q)
		!dpv1Mode |=> !extFuncEnable) else $error("extended functions in legacy mode"); // (RULE11)
	c_sync: cover property (@(posedge core_clk) disable iff (!rstN_q) $fell(outputsLive));
	c_freeze: cover property (@(posedge core_clk) disable iff (!rstN_q) cpuInputLoad);
	c_topo: cover property (@(posedge core_clk) disable iff (!rstN_q) topoFrame);
endmodule

/* File: testbench/fbm_slave_model.sv */
// Purpose: behavioural model of the slave stations on the far side of the master
// Assumes: synchronous to core_clk; frames answered after a short or a long delay
// Notes: power-up answers only while live is high, so a silent bus can be staged
`timescale 1ns/10ps
module fbm_slave_model (
	input wire logic core_clk,
	input wire logic live,
	input wire logic slow,
	input wire logic frameStart,
	input wire logic groupFrame,
	input wire logic [3:0] groupCtrl,
	input wire logic topoFrame,
	output logic frameDone,
	output logic frameBusy,
	output logic slaveParamDone,
	output logic slaveReadyDone,
	output logic syncHeld,
	output logic inputsHeld
);
	int upCnt = 0;
	int frmCnt = 0;
	initial begin
		frameDone = 1'b0;
		frameBusy = 1'b0;
		slaveParamDone = 1'b0;
		slaveReadyDone = 1'b0;
		syncHeld = 1'b0;
		inputsHeld = 1'b0;
	end
	always @(posedge core_clk) begin
		upCnt <= live ? upCnt + 1 : 0;
		slaveParamDone <= live && upCnt >= 10;
		slaveReadyDone <= live && upCnt >= 20;
		frameDone <= 1'b0;
		// control and scan frames are answered like data frames, so the master can move on
		if (frameStart || groupFrame || topoFrame) begin
			frameBusy <= 1'b1;
			frmCnt <= slow ? 12 : 3;
		end else if (frameBusy) begin
			if (frmCnt == 1) begin
				frameBusy <= 1'b0;
				frameDone <= 1'b1;
			end
			frmCnt <= frmCnt - 1;
		end
		// each sync sets syncHeld and keeps it set until an unsync clears it; no output data is modelled
		if (groupFrame && groupCtrl[1]) begin
			syncHeld <= 1'b1;
		end else if (groupFrame && groupCtrl[0]) begin
			syncHeld <= 1'b0;
		end
		if (groupFrame && groupCtrl[3]) begin
			inputsHeld <= 1'b1;
		end else if (groupFrame && groupCtrl[2]) begin
			inputsHeld <= 1'b0;
		end
	end
endmodule

/* File: testbench/test_fieldbus_master_sync_freeze.sv */
// Purpose: self-checking bench for the fieldbus master scheduler
// Assumes: slave model answers frames; blink phases too long to watch
// Notes: equidistance shortened to 40 cycles to keep the run brief
`timescale 1ns/10ps
`include "fbm_defs.svh"
module test_fieldbus_master_sync_freeze;
	logic core_clk = 0, arst_n = 0, dpv1Mode = 0, equidistOn = 0, startUp = 0, cmdValid = 0;
	logic [6:0] ownAddress = 7'h00;
	logic [15:0] equidistCycles = 16'h0028, paramTimeout = 16'h0064, readyTimeout = 16'h0064;
	logic [3:0] cmdCode = 4'h0, groupCtrl;
	logic [7:0] cmdGroups = 8'h00, puTask = 8'h00, groupSel;
	logic puReq = 0, topoReq = 0, pgTraffic = 0, slaveMissing = 0, busHwFault = 0, reconfigBusy = 0;
	logic live = 0, slow = 0, puOutput = 0, cmdReady, puAccepted, puRejected, topoFrame, frameDone, frameStart;
	logic groupFrame, outputsLive, inputsLive, cpuInputLoad, extFuncEnable, powerUpFail, addrValid;
	logic busFaultLamp, intFaultLamp, frameBusy, pDone, rDone;
	logic [5:0] ev;
	int n_errors = 0, cmp_count = 0, cycles = 0, g1, g2, g3;
	assign ev = {topoFrame, puRejected, puAccepted, powerUpFail, frameStart, groupFrame};
	fbm_master fbm_master_i (.core_clk(core_clk), .arst_n(arst_n), .ownAddress(ownAddress),
		.dpv1Mode(dpv1Mode), .equidistOn(equidistOn), .equidistCycles(equidistCycles),
		.paramTimeout(paramTimeout), .readyTimeout(readyTimeout), .startUp(startUp),
		.cmdValid(cmdValid), .cmdCode(cmdCode), .cmdGroups(cmdGroups), .cmdReady(cmdReady),
		.puReq(puReq), .puTask(puTask), .puOutput(puOutput), .puAccepted(puAccepted),
		.puRejected(puRejected), .topoReq(topoReq), .topoFrame(topoFrame), .pgTraffic(pgTraffic),
		.slaveParamDone(pDone), .slaveReadyDone(rDone), .slaveMissing(slaveMissing),
		.busHwFault(busHwFault), .reconfigBusy(reconfigBusy), .frameDone(frameDone),
		.frameStart(frameStart), .groupFrame(groupFrame), .groupCtrl(groupCtrl), .groupSel(groupSel),
		.outputsLive(outputsLive), .inputsLive(inputsLive), .cpuInputLoad(cpuInputLoad),
		.extFuncEnable(extFuncEnable), .powerUpFail(powerUpFail), .addrValid(addrValid),
		.busFaultLamp(busFaultLamp), .intFaultLamp(intFaultLamp));
	fbm_slave_model fbm_slave_model_i (.core_clk(core_clk), .live(live), .slow(slow),
		.frameStart(frameStart), .groupFrame(groupFrame), .groupCtrl(groupCtrl), .topoFrame(topoFrame),
		.frameDone(frameDone),
		.frameBusy(frameBusy), .slaveParamDone(pDone), .slaveReadyDone(rDone), .syncHeld(),
		.inputsHeld());
	initial begin
		forever #5 core_clk = ~core_clk;
	end
	task stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, n_errors);
		if (n_errors == 0 && cmp_count > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	// a stuck design must still reach the report
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			n_errors++;
			stop_test();
		end
	end
	task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		cmp_count++;
		if (g !== e) begin
			n_errors++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task wait_ev(input int b, input int lim, output logic hit);
		hit = 1'b0;
		for (int k = 0; k < lim && !hit; k++) begin
			@(negedge core_clk);
			hit = (ev[b] === 1'b1);
		end
	endtask
	task gap(output int n);
		logic h;
		wait_ev(1, 500, h);
		n = 0;
		do begin
			@(negedge core_clk);
			n++;
		end while (frameStart !== 1'b1 && n < 500);
	endtask
	task cmd(input logic [3:0] c, input logic [7:0] g);
		logic h;
		@(posedge core_clk);
		cmdValid <= 1'b1;
		cmdCode <= c;
		cmdGroups <= g;
		do @(posedge core_clk); while (cmdReady !== 1'b1);
		cmdValid <= 1'b0;
		wait_ev(0, 500, h);
		chk("groupFrame", 1, h);
		chk("groupCtrl", c, groupCtrl);
		chk("groupSel", g, groupSel);
		chk("cpuInputLoad", c[3], cpuInputLoad);
		chk("frameBusy", 0, frameBusy);
	endtask
	task pulse_pu(input logic [7:0] t, input logic acc);
		@(posedge core_clk);
		puReq <= 1'b1;
		puTask <= t;
		puOutput <= t[0];
		@(posedge core_clk);
		puReq <= 1'b0;
		// both answers are one-cycle pulses, so they are read in the same cycle
		@(negedge core_clk);
		chk("puAccepted", acc, puAccepted);
		chk("puRejected", !acc, puRejected);
	endtask
	task set_hw(input logic f, input logic m, input logic rc);
		@(posedge core_clk);
		busHwFault <= f;
		slaveMissing <= m;
		reconfigBusy <= rc;
		repeat (12) @(negedge core_clk);
	endtask
	initial begin
		logic h;
		repeat (4) @(posedge core_clk);
		arst_n <= 1'b1;
		repeat (5) @(posedge core_clk);
		ownAddress <= 7'h7e;
		@(negedge core_clk);
		chk("addrValid", 1, addrValid);
		@(posedge core_clk);
		ownAddress <= 7'h7f;
		@(negedge core_clk);
		chk("addrValid", 0, addrValid);
		@(posedge core_clk);
		dpv1Mode <= 1'b1;
		repeat (2) @(negedge core_clk);
		chk("extFuncEnable", 1, extFuncEnable);
		@(posedge core_clk);
		dpv1Mode <= 1'b0;
		repeat (2) @(negedge core_clk);
		chk("extFuncEnable", 0, extFuncEnable);
		@(posedge core_clk);
		startUp <= 1'b1;
		@(posedge core_clk);
		startUp <= 1'b0;
		wait_ev(2, 400, h);
		chk("powerUpFail", 1, h);
		@(posedge core_clk);
		live <= 1'b1;
		startUp <= 1'b1;
		@(posedge core_clk);
		startUp <= 1'b0;
		wait_ev(1, 400, h);
		chk("frameStart", 1, h);
		chk("powerUpFail", 0, powerUpFail);
		@(posedge core_clk);
		equidistOn <= 1'b1;
		gap(g1);
		gap(g1);
		gap(g2);
		chk("equalGap", g1, g2);
		chk("gapAtLeast", 1, g1 >= 40);
		@(posedge core_clk);
		pgTraffic <= 1'b1;
		@(posedge core_clk);
		pgTraffic <= 1'b0;
		gap(g2);
		gap(g3);
		chk("longerGap", 1, g2 > g1 || g3 > g1);
		@(posedge core_clk);
		slow <= 1'b1;
		cmd(`FBM_CMD_SYNC, 8'h05);
		chk("outputsLive", 0, outputsLive);
		cmd(`FBM_CMD_SYNC, 8'h05);
		chk("outputsLive", 0, outputsLive);
		cmd(`FBM_CMD_UNSYNC, 8'h05);
		chk("outputsLive", 1, outputsLive);
		cmd(`FBM_CMD_FREEZE, 8'h80);
		chk("inputsLive", 0, inputsLive);
		cmd(`FBM_CMD_UNFREEZE, 8'h80);
		chk("inputsLive", 1, inputsLive);
		pulse_pu(8'h3c, 1'b0);
		pulse_pu(8'h3d, 1'b1);
		pulse_pu(8'h40, 1'b1);
		pulse_pu(8'h41, 1'b0);
		@(posedge core_clk);
		topoReq <= 1'b1;
		@(posedge core_clk);
		topoReq <= 1'b0;
		// the scan waits for the frame in progress, which may be a long one
		wait_ev(5, 100, h);
		chk("topoFrame", 1, h);
		set_hw(1'b1, 1'b1, 1'b0);
		chk("busFaultLamp", 1, busFaultLamp);
		repeat (5) @(negedge core_clk);
		chk("busFaultLamp", 1, busFaultLamp);
		set_hw(1'b0, 1'b0, 1'b0);
		chk("busFaultLamp", 0, busFaultLamp);
		set_hw(1'b0, 1'b0, 1'b1);
		chk("intFaultLamp", 1, intFaultLamp);
		set_hw(1'b0, 1'b0, 1'b0);
		stop_test();
	end
endmodule
